// >>> isp_boot_pkg.sv
// constants, register map and carrier types for the isp boot/security control block
// assumes one 10 MHz clock domain and an axi4-lite master on the register side
// Function
// - writing bit 7 with bits 1 and 0 set causes a power-on-like reset
// - bit 7 reads 1 while running in loader boot mode
// - bit 4 enables the auxiliary ram
// - bit 1 selects loader location and reprogramming target bank
// - bit 0 set: programming mode entered on wake from idle, or on idle alone in loader boot mode
// - bit 0 clear: program memory read-only, programming refused
// - after power-on boot from application bank unless loader boot condition
// - loader boot if p2.7 and p2.6 low, or p4.3 low
// - security and id registers unreachable in programming mode
// - a security bit programmed to 0 stays 0 until erase-all; here aresetn also restores it to 1
// - security register sits at top address of loader bank space
// - security bits default to 1, no protection
// - lock bit 0 refuses program memory and setting register access
// - read-restriction 0: external table reads cannot reach internal code
// - table reads from internal code always reach both memories
// - encryption bit 0 encodes port 0 data; only erase-all clears it; here aresetn also restores it to 1
// - oscillator bit 0 gives half gain, 1 full gain
// - maker and part ids are fixed read-only 8-bit values
// - control register writable only after 87h then 59h unlock sequence
// - loader boot entry and wake into programming mode clear the program counter

package isp_boot_pkg;

    // =====================================================================
    // register map (byte addresses; printed offset 0xbf is a register index)
    localparam logic [7:0]  CTRL_INDEX      = 8'hbf;
    localparam logic [11:0] ADDR_CTRL       = {2'b00, CTRL_INDEX, 2'b00};
    localparam logic [11:0] ADDR_UNLOCK     = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [11:0] ADDR_SEC        = 12'h008;
    localparam logic [11:0] ADDR_SEC_CMD    = 12'h00c;
    localparam logic [11:0] ADDR_ID         = 12'h010;
    localparam logic [11:0] ADDR_ISP_CMD    = 12'h014;

    localparam logic [15:0] SEC_REG_ADDR    = 16'hffff;

    // =====================================================================
    // field positions
    localparam int CTRL_RESET_BIT  = 7;
    localparam int CTRL_AUXRAM_BIT = 4;
    localparam int CTRL_BANK_BIT   = 1;
    localparam int CTRL_PROG_BIT   = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h13;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam int SEC_LOCK_BIT  = 0;
    localparam int SEC_CODE_TABLE_READ_BIT  = 1;
    localparam int SEC_ENC_BIT   = 2;
    localparam int SEC_OSC_BIT   = 7;
    localparam logic [7:0] SEC_DEFAULT   = 8'hff;
    localparam logic [7:0] SEC_PROG_MASK = 8'h87;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h87;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h59;

    // security command register: bit 0 programs bits, bit 1 erases all
    localparam int SEC_CMD_PROG_BIT  = 0;
    localparam int SEC_CMD_ERASE_BIT = 1;

    // identity values, arbitrary
    localparam logic [7:0] MAKER_ID = 8'h3c;
    localparam logic [7:0] PART_ID  = 8'h15;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum {
        RUN_APP,
        RUN_LOADER_BOOT,
        IDLE_WAIT,
        ISP_MODE
    } run_state_t;

    typedef struct packed {
        logic        code_table_read_from_ext;
        logic        target_internal;
    } table_read_t;

    typedef struct packed {
        logic        aux_ram_enable;
        logic        run_from_loader;
        logic        isp_active;
        logic        encrypt_port0;
        logic        osc_half_gain;
        logic        soft_reset;
        logic        pc_clear;
    } core_ctl_t;

endpackage

// >>> isp_boot_ctrl.sv
// isp control register, loader-boot strap capture and one-way security bits
// assumes core signals (idle, wake, table read, isp request) are on aclk;
// strap pins are asynchronous and pass three flip-flops
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module isp_boot_ctrl
    import isp_boot_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // strap pins
    input  wire logic        pin_p2_6,
    input  wire logic        pin_p2_7,
    input  wire logic        pin_p4_3,
    // core
    input  wire logic        core_idle,
    input  wire logic        core_wake,
    input  wire logic        isp_req,
    input  wire logic [15:0] isp_addr,
    input  wire table_read_t table_rd,
    output logic             isp_grant,
    output logic             isp_refused,
    output logic             table_rd_allow,
    output core_ctl_t        core_ctl
);

    // =====================================================================
    // strap synchroniser and reset-time capture
    logic [2:0] strap_a_reg, strap_b_reg;
    logic       strap_valid_reg, loader_boot_mode_reg, soft_reset_reg;
    logic       strap_low;

    always_ff @(posedge aclk) begin
        strap_a_reg <= {strap_a_reg[1:0], ~(pin_p2_6 | pin_p2_7)};
        strap_b_reg <= {strap_b_reg[1:0], ~pin_p4_3};
    end

    // value counts only once stages two and three agree
    assign strap_low = (strap_a_reg[1] & strap_a_reg[2]) |
                       (strap_b_reg[1] & strap_b_reg[2]);

    // caught after reset release, once the chain has settled
    logic [1:0] settle_reg;
    // soft reboot resamples the straps, as a power-on would
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_reg) begin
            settle_reg           <= 2'd0;
            strap_valid_reg      <= 1'b0;
            loader_boot_mode_reg <= 1'b0;
        end else if (!strap_valid_reg) begin
            settle_reg <= settle_reg + 2'd1;
            if (settle_reg == 2'd3) begin
                strap_valid_reg      <= 1'b1;
                loader_boot_mode_reg <= strap_low;
            end
        end
    end

    // =====================================================================
    // axi4-lite write channel
    logic        aw_held_reg, w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;

    assign s_awready = !aw_held_reg && !s_bvalid;
    assign s_wready  = !w_held_reg && !s_bvalid;
    assign wr_fire   = aw_held_reg && w_held_reg && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 12'h000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_wdata;
                wstrb_reg  <= s_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    function automatic logic mapped(input logic [11:0] a);
        if (a == ADDR_CTRL)         mapped = 1'b1;
        else if (a == ADDR_UNLOCK)  mapped = 1'b1;
        else if (a == ADDR_STATUS)  mapped = 1'b1;
        else if (a == ADDR_SEC)     mapped = 1'b1;
        else if (a == ADDR_SEC_CMD) mapped = 1'b1;
        else if (a == ADDR_ID)      mapped = 1'b1;
        else if (a == ADDR_ISP_CMD) mapped = 1'b1;
        else                        mapped = 1'b0;
    endfunction

    logic wr_lane0;
    assign wr_lane0 = wr_fire && wstrb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_bvalid <= 1'b1;
            s_bresp  <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // =====================================================================
    // unlock sequence
    logic key1_seen_reg, write_open_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key1_seen_reg  <= 1'b0;
            write_open_reg <= 1'b0;
        end else if (wr_lane0 && awaddr_reg == ADDR_UNLOCK) begin
            // any other value closes the write window again
            key1_seen_reg  <= (wdata_reg[7:0] == UNLOCK_KEY1);
            write_open_reg <= key1_seen_reg && (wdata_reg[7:0] == UNLOCK_KEY2);
        end
    end

    // =====================================================================
    // control register
    logic [7:0] ctrl_reg;
    logic       ctrl_wr;

    assign ctrl_wr = wr_lane0 && awaddr_reg == ADDR_CTRL && write_open_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_reg) begin
            ctrl_reg <= CTRL_RESET;
        end else if (ctrl_wr) begin
            // bits 3,2 forced to 0 and 6,5 reserved
            ctrl_reg <= wdata_reg[7:0] & CTRL_WMASK;
        end
    end

    // reset strobe: bit 7 with bank select and program enable all set
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_reg) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= ctrl_wr && wdata_reg[CTRL_RESET_BIT]
                              && wdata_reg[CTRL_BANK_BIT] && wdata_reg[CTRL_PROG_BIT];
        end
    end

    // =====================================================================
    // run state: application, loader boot, isp via idle wake (from loader boot, via idle alone)
    run_state_t state_reg;
    logic       pc_clear_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_reg) begin
            state_reg    <= RUN_APP;
            pc_clear_reg <= 1'b0;
        end else begin
            pc_clear_reg <= 1'b0;
            case (state_reg)
                RUN_APP: begin
                    if (strap_valid_reg && loader_boot_mode_reg) begin
                        state_reg    <= RUN_LOADER_BOOT;
                        pc_clear_reg <= 1'b1;
                    end else if (core_idle && ctrl_reg[CTRL_PROG_BIT]) begin
                        state_reg <= IDLE_WAIT;
                    end
                end
                RUN_LOADER_BOOT: begin
                    if (core_idle && ctrl_reg[CTRL_PROG_BIT]) begin
                        state_reg <= ISP_MODE;
                    end
                end
                IDLE_WAIT: begin
                    if (!ctrl_reg[CTRL_PROG_BIT]) begin
                        state_reg <= RUN_APP;
                    end else if (core_wake) begin
                        state_reg    <= ISP_MODE;
                        pc_clear_reg <= 1'b1;
                    end
                end
                ISP_MODE: begin
                    if (!ctrl_reg[CTRL_PROG_BIT]) begin
                        state_reg <= RUN_APP;
                    end
                end
                default: state_reg <= RUN_APP;
            endcase
        end
    end

    // =====================================================================
    // security bits, one-way until erase-all or aresetn
    logic [7:0] sec_reg;
    logic       sec_cmd_wr;

    assign sec_cmd_wr = wr_lane0 && awaddr_reg == ADDR_SEC_CMD;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_reg <= SEC_DEFAULT;
        end else if (sec_cmd_wr && wdata_reg[SEC_CMD_ERASE_BIT]) begin
            sec_reg <= SEC_DEFAULT;
        end else if (sec_cmd_wr && wdata_reg[SEC_CMD_PROG_BIT]
                     && sec_reg[SEC_LOCK_BIT] && state_reg != ISP_MODE) begin
            // only clears bits; reserved bits kept high
            sec_reg <= sec_reg & (wdata_reg[15:8] | ~SEC_PROG_MASK);
        end
    end

    // =====================================================================
    // isp access arbitration
    logic in_isp, sec_target;
    assign in_isp     = state_reg == ISP_MODE;
    assign sec_target = ctrl_reg[CTRL_BANK_BIT] == 1'b0 && isp_addr == SEC_REG_ADDR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isp_grant   <= 1'b0;
            isp_refused <= 1'b0;
        end else begin
            isp_grant   <= isp_req && in_isp && core_idle && ctrl_reg[CTRL_PROG_BIT]
                           && !sec_target && sec_reg[SEC_LOCK_BIT];
            isp_refused <= isp_req && !(in_isp && core_idle && ctrl_reg[CTRL_PROG_BIT]
                           && !sec_target && sec_reg[SEC_LOCK_BIT]);
        end
    end

    // internal-code table reads from external code blocked when bit 1 is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            table_rd_allow <= 1'b1;
        end else begin
            table_rd_allow <= !(table_rd.code_table_read_from_ext && table_rd.target_internal
                                && !sec_reg[SEC_CODE_TABLE_READ_BIT]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ctl <= '0;
        end else begin
            core_ctl.aux_ram_enable  <= ctrl_reg[CTRL_AUXRAM_BIT];
            core_ctl.run_from_loader <= ctrl_reg[CTRL_BANK_BIT] || state_reg != RUN_APP;
            core_ctl.isp_active      <= in_isp;
            core_ctl.encrypt_port0   <= !sec_reg[SEC_ENC_BIT];
            core_ctl.osc_half_gain   <= !sec_reg[SEC_OSC_BIT];
            core_ctl.soft_reset      <= soft_reset_reg;
            core_ctl.pc_clear        <= pc_clear_reg;
        end
    end

    // =====================================================================
    // axi4-lite read channel
    logic [7:0] ctrl_view;
    assign ctrl_view = {(state_reg == RUN_LOADER_BOOT), ctrl_reg[6:0]};

    assign s_arready = !s_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= RESP_OKAY;
            if (s_araddr == ADDR_CTRL) begin
                s_rdata <= {24'h000000, ctrl_view};
            end else if (s_araddr == ADDR_UNLOCK) begin
                s_rdata <= {31'h0, write_open_reg};
            end else if (s_araddr == ADDR_STATUS) begin
                s_rdata <= {28'h0, loader_boot_mode_reg, strap_valid_reg,
                            in_isp, state_reg == IDLE_WAIT};
            end else if (s_araddr == ADDR_SEC) begin
                // locked or in isp: setting registers hidden
                s_rdata <= (sec_reg[SEC_LOCK_BIT] && !in_isp) ? {24'h000000, sec_reg}
                                                              : 32'h0000_0000;
            end else if (s_araddr == ADDR_ID) begin
                s_rdata <= (sec_reg[SEC_LOCK_BIT] && !in_isp) ?
                           {16'h0000, PART_ID, MAKER_ID} : 32'h0000_0000;
            end else if (s_araddr == ADDR_SEC_CMD || s_araddr == ADDR_ISP_CMD) begin
                s_rdata <= 32'h0000_0000;
            end else begin
                s_rdata <= 32'h0000_0000;
                s_rresp <= RESP_SLVERR;
            end
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

endmodule // isp_boot_ctrl

`default_nettype wire

// >>> isp_boot_ctrl_properties.sv
// port-level assertions for the isp boot and security control block
// assumes it is bound to isp_boot_ctrl, one aclk domain, sync active-low reset
`timescale 1ns/1ns
`default_nettype none

module isp_boot_ctrl_checker
    import isp_boot_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        core_wake,
    input wire logic        isp_req,
    input wire table_read_t table_rd,
    input wire logic        isp_grant,
    input wire logic        isp_refused,
    input wire logic        table_rd_allow,
    input wire core_ctl_t   core_ctl,
    input wire logic [11:0] s_araddr,
    input wire logic        s_arvalid,
    input wire logic        s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic        s_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ======================================================================
    // assertions
    a_reboot_pulse: assert property ($rose(core_ctl.soft_reset) |=>
        !core_ctl.soft_reset ##1 !core_ctl.aux_ram_enable) else $error("reboot pulse bad");
    a_grant_cause: assert property (isp_grant |-> $past(isp_req) && !isp_refused)
        else $error("grant without request");
    a_refuse_outside: assert property (isp_req && !core_ctl.isp_active |=> isp_refused)
        else $error("request outside isp not refused");
    a_no_isp_grant: assert property (!core_ctl.isp_active |=> !isp_grant)
        else $error("grant outside isp");
    a_internal_table: assert property (!table_rd.code_table_read_from_ext |=> table_rd_allow)
        else $error("internal table read blocked");
    // security and id reads still complete in isp mode, they just show nothing
    a_setting_hidden: assert property (s_arvalid && s_arready && core_ctl.isp_active &&
        (s_araddr == ADDR_SEC || s_araddr == ADDR_ID) |=> s_rvalid && s_rdata == 32'h0)
        else $error("setting register visible in isp");
    a_pc_clear_cause: assert property (core_ctl.pc_clear |->
        $past(core_wake) || core_ctl.run_from_loader) else $error("pc clear without cause");
    a_pc_clear_pulse: assert property (core_ctl.pc_clear |=> !core_ctl.pc_clear)
        else $error("pc clear too long");

    c_grant: cover property (isp_grant);
    c_reboot: cover property ($rose(core_ctl.soft_reset));
    c_loader: cover property ($rose(core_ctl.run_from_loader));
endmodule // isp_boot_ctrl_checker

bind isp_boot_ctrl isp_boot_ctrl_checker chk (
    .aclk(aclk), .aresetn(aresetn), .core_wake(core_wake), .isp_req(isp_req),
    .table_rd(table_rd), .isp_grant(isp_grant), .isp_refused(isp_refused),
    .table_rd_allow(table_rd_allow), .core_ctl(core_ctl), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid)
);

`default_nettype wire

// >>> strap_core_model.sv
// strap jumpers and core sleep/wake seen by the isp boot block
// assumes the bench picks the strap mode before reset and holds it through it
`timescale 1ns/1ns
`default_nettype none

module strap_core_model #(
    parameter int WAKE_DELAY = 4
) (
    input  wire logic       aclk,
    input  wire logic [1:0] strap_mode,
    input  wire logic       nap,
    output var logic        pin_p2_6 = 1'b1,
    output var logic        pin_p2_7 = 1'b1,
    output var logic        pin_p4_3 = 1'b1,
    output var logic        core_idle = 1'b0,
    output var logic        core_wake = 1'b0
);
    int cnt = 0;

    // ======================================================================
    // jumpers: held steady, never floating, so no boot mode by accident
    always @(posedge aclk) begin
        pin_p2_6 <= (strap_mode != 2'd1);
        pin_p2_7 <= (strap_mode != 2'd1);
        pin_p4_3 <= (strap_mode != 2'd2);
    end

    // ======================================================================
    // timer interrupt wakes the core a fixed time after it naps
    always @(posedge aclk) begin
        core_idle <= nap;
        core_wake <= nap && (cnt == WAKE_DELAY);
        cnt <= nap ? cnt + 1 : 0;
    end
endmodule // strap_core_model

`default_nettype wire

// >>> isp_boot_security_control_test.sv
// self-checking bench for the isp boot and security control block
// assumes checker bind and strap/core model compile before this file
`timescale 1ns/1ns
`default_nettype none

module isp_boot_security_control_test
    import isp_boot_pkg::*;
;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic [1:0]  r;
    } row_t;

    logic aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, isp_req = 1'b0, nap = 1'b0;
    logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd_d;
    logic [15:0] isp_addr = 16'h0;
    logic [1:0]  s_bresp, s_rresp, rsp, strap_mode = 2'd0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, isp_grant, isp_refused;
    logic table_rd_allow, pin_p2_6, pin_p2_7, pin_p4_3, core_idle, core_wake;
    table_read_t table_rd = '0;
    core_ctl_t   core_ctl;
    int errors = 0, total_checks = 0;

    // ======================================================================
    // ordinary register traffic: write, addr, data, expected read, response
    row_t rows [15] = '{
        '{1'b0, ADDR_CTRL, 32'h0, 32'h0, RESP_OKAY},
        '{1'b1, ADDR_CTRL, 32'h13, 32'h0, RESP_OKAY},
        '{1'b0, ADDR_CTRL, 32'h0, 32'h0, RESP_OKAY},
        '{1'b1, ADDR_UNLOCK, 32'h87, 32'h0, RESP_OKAY},
        '{1'b1, ADDR_UNLOCK, 32'h59, 32'h0, RESP_OKAY},
        '{1'b0, ADDR_UNLOCK, 32'h0, 32'h1, RESP_OKAY},
        '{1'b1, ADDR_CTRL, 32'h11, 32'h0, RESP_OKAY},
        '{1'b0, ADDR_CTRL, 32'h0, 32'h11, RESP_OKAY},
        '{1'b0, ADDR_SEC, 32'h0, 32'hff, RESP_OKAY},
        '{1'b0, ADDR_ID, 32'h0, {16'h0, PART_ID, MAKER_ID}, RESP_OKAY},
        '{1'b0, 12'h100, 32'h0, 32'h0, RESP_SLVERR},
        '{1'b1, ADDR_SEC_CMD, 32'h7f01, 32'h0, RESP_OKAY},
        '{1'b0, ADDR_SEC, 32'h0, 32'h7f, RESP_OKAY},
        '{1'b1, ADDR_SEC_CMD, 32'hff01, 32'h0, RESP_OKAY},
        '{1'b0, ADDR_SEC, 32'h0, 32'h7f, RESP_OKAY}
    };

    isp_boot_ctrl dut (
        .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .pin_p2_6(pin_p2_6), .pin_p2_7(pin_p2_7), .pin_p4_3(pin_p4_3),
        .core_idle(core_idle), .core_wake(core_wake), .isp_req(isp_req),
        .isp_addr(isp_addr), .table_rd(table_rd), .isp_grant(isp_grant),
        .isp_refused(isp_refused), .table_rd_allow(table_rd_allow), .core_ctl(core_ctl)
    );

    strap_core_model far_side (
        .aclk(aclk), .strap_mode(strap_mode), .nap(nap), .pin_p2_6(pin_p2_6),
        .pin_p2_7(pin_p2_7), .pin_p4_3(pin_p4_3), .core_idle(core_idle),
        .core_wake(core_wake)
    );

    initial forever #50 aclk = ~aclk;

    // ======================================================================
    // tasks
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("mismatches %0d of %0d checks", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic give_up;
        errors++;
        $display("[ERR] %0t no answer", $time);
        wrap_up();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid && n < 50);
        r = s_bresp;
        s_bready <= 1'b0;
        if (n >= 50) give_up();
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid && n < 50);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        if (n >= 50) give_up();
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] x);
        rd(a, rd_d, rsp);
        chk({rsp, rd_d}, {RESP_OKAY, x});
    endtask

    task automatic put(input logic [11:0] a, input logic [31:0] d);
        wr(a, d, rsp);
        chk({rsp, 32'h0}, {RESP_OKAY, 32'h0});
    endtask

    task automatic unlock;
        put(ADDR_UNLOCK, 32'h87);
        put(ADDR_UNLOCK, 32'h59);
    endtask

    task automatic wait_isp(input logic v);
        int n;
        n = 0;
        while (core_ctl.isp_active !== v && n < 50) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 50) give_up();
    endtask

    // straps are sampled a few edges after release, so settle first
    task automatic do_reset(input logic [1:0] m);
        @(posedge aclk);
        strap_mode <= m;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask

    // ======================================================================
    // main sequence
    initial begin
        do_reset(2'd0);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d, rsp);
            else rd(rows[i].a, rd_d, rsp);
            chk({rsp, rows[i].w ? 32'h0 : rd_d}, {rows[i].r, rows[i].x});
        end
        @(negedge aclk) chk(core_ctl.osc_half_gain, 1'b1);
        @(negedge aclk) chk(core_ctl.aux_ram_enable, 1'b1);
        @(posedge aclk);
        nap <= 1'b1;
        wait_isp(1'b1);
        @(posedge aclk);
        isp_req <= 1'b1;
        isp_addr <= 16'h1234;
        @(posedge aclk);
        @(negedge aclk) chk(isp_grant, 1'b1);
        @(posedge aclk);
        isp_addr <= SEC_REG_ADDR;
        @(posedge aclk);
        @(negedge aclk) chk(isp_refused, 1'b1);
        @(posedge aclk);
        isp_req <= 1'b0;
        rchk(ADDR_SEC, 32'h0);
        rchk(ADDR_ID, 32'h0);
        nap <= 1'b0;
        unlock();
        put(ADDR_CTRL, 32'h10);
        wait_isp(1'b0);
        @(posedge aclk);
        isp_req <= 1'b1;
        table_rd <= '{1'b1, 1'b1};
        @(posedge aclk);
        @(negedge aclk) chk(isp_refused, 1'b1);
        @(negedge aclk) chk(table_rd_allow, 1'b1);
        @(posedge aclk);
        isp_req <= 1'b0;
        put(ADDR_SEC_CMD, 32'hf901);
        rchk(ADDR_SEC, 32'h79);
        @(negedge aclk) chk(table_rd_allow, 1'b0);
        @(negedge aclk) chk(core_ctl.encrypt_port0, 1'b1);
        @(posedge aclk);
        table_rd <= '{1'b0, 1'b1};
        @(posedge aclk);
        @(negedge aclk) chk(table_rd_allow, 1'b1);
        put(ADDR_SEC_CMD, 32'h2);
        rchk(ADDR_SEC, 32'hff);
        @(negedge aclk) chk(core_ctl.encrypt_port0, 1'b0);
        @(negedge aclk) chk(core_ctl.osc_half_gain, 1'b0);
        put(ADDR_CTRL, 32'h83);
        rchk(ADDR_CTRL, 32'h0);
        for (int m = 1; m < 3; m++) begin
            do_reset(m[1:0]);
            rchk(ADDR_CTRL, 32'h80);
            @(negedge aclk) chk(core_ctl.run_from_loader, 1'b1);
        end
        @(posedge aclk);
        strap_mode <= 2'd0;
        unlock();
        put(ADDR_CTRL, 32'h83);
        repeat (8) @(posedge aclk);
        @(negedge aclk) chk(core_ctl.run_from_loader, 1'b0);
        put(ADDR_CTRL, 32'h2);
        @(negedge aclk) chk(core_ctl.run_from_loader, 1'b1);
        put(ADDR_SEC_CMD, 32'hfe01);
        rchk(ADDR_SEC, 32'h0);
        rchk(ADDR_ID, 32'h0);
        wrap_up();
    end
endmodule // isp_boot_security_control_test

`default_nettype wire
